// *** rtl/spmfc_top.sv ***
// Per-port MAC control: gap timing, half-duplex collision handling, pause
// reception and generation, back pressure, receive size, self-address and
// storm filtering. Assumes one AHB-Lite master, same-clock queue and rx
// descriptor logic, and carrier/collision pins from the PHY (asynchronous).
`timescale 1ns/10ps
`include "spmfc_cfg.svh"

module spmfc_top import spmfc_pkg::*; #(
  parameter int unsigned P_SLOT_10M_CYC   = `SPMFC_SLOT_10M_CYC,
  parameter int unsigned P_STORM_1G_CYC   = `SPMFC_MS_CYC(`SPMFC_STORM_1G_MS),
  parameter int unsigned P_STORM_100M_CYC = `SPMFC_MS_CYC(`SPMFC_STORM_100M_MS),
  parameter int unsigned P_STORM_10M_CYC  = `SPMFC_MS_CYC(`SPMFC_STORM_10M_MS)
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Link state and PHY pins
  input  wire spmfc_link_type       link,
  input  wire logic                 crs_pin,
  input  wire logic                 col_pin,
  // Egress queue and resources
  input  wire spmfc_txq_type        txq,
  input  wire spmfc_res_type        res,
  output spmfc_tx_out_type          tx_out,
  output logic [47:0]               pause_sa,
  // Receive descriptors
  input  wire spmfc_rx_desc_type    rx_desc,
  output spmfc_rx_verdict_type      rx_verdict
);

  spmfc_state_type s, n;

  logic        fd;
  logic        paused;
  logic        bp_want;
  logic        res_low;
  logic        res_high;
  logic [15:0] slot_c;
  logic [15:0] ipg_c;
  logic [25:0] storm_c;
  logic [13:0] max_len;
  logic [20:0] storm_lim;
  logic [20:0] storm_sum;
  logic [9:0]  bo_mask;
  logic        storm_cls;
  logic [4:0]  col_nx;

  ////////////////////////////////////////////////////////////////////////////
  // Per-speed counts
  always_comb begin
    case (link.speed)
      2'd2: begin
        slot_c  = 16'(`SPMFC_SLOT_CYC(1));
        ipg_c   = 16'(`SPMFC_IPG_CYC(1));
        storm_c = 26'(P_STORM_1G_CYC);
      end
      2'd1: begin
        slot_c  = 16'(`SPMFC_SLOT_CYC(10));
        ipg_c   = 16'(`SPMFC_IPG_CYC(10));
        storm_c = 26'(P_STORM_100M_CYC);
      end
      default: begin
        slot_c  = 16'(P_SLOT_10M_CYC);
        ipg_c   = 16'(`SPMFC_IPG_CYC(100));
        storm_c = 26'(P_STORM_10M_CYC);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived conditions
  assign fd        = link.full_duplex;
  assign paused    = (s.pause_cnt != 16'h0000);
  assign res_low   = (res.free_buf < s.thr_on) || (res.free_q < s.thr_on);
  assign res_high  = (res.free_buf >= s.thr_off) && (res.free_q >= s.thr_off);
  assign bp_want   = !fd && s.ctrl[`SPMFC_BPEN_BIT] && s.fc_need;
  assign max_len   = s.ctrl[`SPMFC_JUMBO_BIT] ? `SPMFC_MAX_JUMBO : `SPMFC_MAX_STD;
  assign storm_lim = 21'(`SPMFC_STORM_UNIT) * 21'(s.storm_pct);
  assign storm_sum = s.storm_bytes + 21'(rx_desc.len);
  assign storm_cls = rx_desc.bcast || (rx_desc.mcast && s.ctrl[`SPMFC_STORMMC_BIT]);
  assign col_nx    = (s.col_cnt == `SPMFC_MAX_COLL) ? s.col_cnt : s.col_cnt + 5'd1;
  assign bo_mask   = 10'((11'h001 << ((col_nx > `SPMFC_BO_LIMIT) ? `SPMFC_BO_LIMIT : col_nx))
                         - 11'h001);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    n = s;
    n.tx.start  = 1'b0;
    n.tx.abort  = 1'b0;
    n.tx.drop   = 1'b0;
    n.rxv.valid = 1'b0;
    n.hreadyout = 1'b1;
    n.hresp     = 1'b0;

    // Pins pass three flops; a change counts once stages two and three agree
    n.crs_s = {s.crs_s[1:0], crs_pin};
    n.col_s = {s.col_s[1:0], col_pin};
    if (s.crs_s[1] == s.crs_s[2]) begin
      n.crs_f = s.crs_s[2];
    end
    if (s.col_s[1] == s.col_s[2]) begin
      n.col_f = s.col_s[2];
    end

    n.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};

    // Bus write data phase
    n.wr_pend = 1'b0;
    if (s.wr_pend) begin
      case (s.wr_addr)
        `SPMFC_CTRL_OFS:  n.ctrl          = hwdata[7:0];
        `SPMFC_MACLO_OFS: n.mac[31:0]     = hwdata;
        `SPMFC_MACHI_OFS: n.mac[47:32]    = hwdata[15:0];
        `SPMFC_STORM_OFS: n.storm_pct     = hwdata[6:0];
        `SPMFC_FCTHR_OFS: begin
          n.thr_on  = hwdata[11:0];
          n.thr_off = hwdata[27:16];
        end
        default: ;
      endcase
    end

    // Flow control need with hysteresis; frames only on full duplex
    if (!s.fc_need && res_low) begin
      n.fc_need = 1'b1;
      if (fd && s.ctrl[`SPMFC_FCEN_BIT]) begin
        n.fc_req    = 1'b1;
        n.fc_quanta = `SPMFC_PAUSE_MAX;
      end
    end else if (s.fc_need && res_high) begin
      n.fc_need = 1'b0;
      if (fd && s.ctrl[`SPMFC_FCEN_BIT]) begin
        n.fc_req    = 1'b1;
        n.fc_quanta = 16'h0000;
      end
    end

    // Pause timer counts down in 512-bit quanta
    if (paused) begin
      if (s.pause_pre >= slot_c - 16'd1) begin
        n.pause_pre = 16'h0000;
        n.pause_cnt = s.pause_cnt - 16'd1;
      end else begin
        n.pause_pre = s.pause_pre + 16'd1;
      end
    end

    // Storm interval: counter cleared at each interval start
    if (s.storm_tmr == 26'h0000000) begin
      n.storm_tmr   = storm_c - 26'h0000001;
      n.storm_bytes = 21'h000000;
    end else begin
      n.storm_tmr = s.storm_tmr - 26'h0000001;
    end

    // Receive verdict, checks in priority order
    if (rx_desc.eof) begin
      n.rxv.valid  = 1'b1;
      n.rxv.pass   = 1'b0;
      n.rxv.reason = RX_OK;
      if (rx_desc.len < `SPMFC_MIN_LEN) begin
        n.rxv.reason = RX_SHORT;
      end else if (rx_desc.len > max_len) begin
        n.rxv.reason = RX_LONG;
      end else if (s.ctrl[`SPMFC_SELFEN_BIT] && rx_desc.sa == s.mac) begin
        n.rxv.reason = RX_SELF;
      end else if (rx_desc.pause) begin
        n.rxv.reason = RX_PAUSE;
        if (fd) begin
          n.pause_cnt = rx_desc.quanta;
          n.pause_pre = 16'h0000;
        end
      end else if (s.ctrl[`SPMFC_STORMEN_BIT] && storm_cls) begin
        if (storm_sum > storm_lim) begin
          n.rxv.reason = RX_STORM;
        end else begin
          n.rxv.pass = 1'b1;
          if (s.storm_tmr != 26'h0000000) begin
            n.storm_bytes = storm_sum;
          end
        end
      end else begin
        n.rxv.pass = 1'b1;
      end
      if (!n.rxv.pass && n.rxv.reason != RX_PAUSE) begin
        n.drops = s.drops + 16'd1;
      end
    end

    // Transmit sequencer
    case (s.tx_st)
      TX_IDLE: begin
        n.tx.carrier = 1'b0;
        n.cnt        = 16'h0000;
        if (s.fc_req && fd) begin
          n.fc_req         = (n.fc_quanta != s.fc_quanta); // New request wins over clear
          n.tx.start       = 1'b1;
          n.tx.pause_frame = 1'b1;
          n.tx.quanta      = s.fc_quanta;
          n.tx_st          = TX_SEND;
        end else if (txq.pending && !(fd && paused)) begin
          n.tx.start       = 1'b1;
          n.tx.pause_frame = 1'b0;
          n.tx.quanta      = 16'h0000;
          n.tx_st          = TX_SEND;
        end else if (bp_want) begin
          n.tx.carrier = 1'b1;
          n.tx_st      = TX_BPCAR;
        end
      end
      TX_SEND: begin
        if (s.cnt < slot_c) begin
          n.cnt = s.cnt + 16'd1;
        end
        if (s.col_f && !fd) begin
          n.tx.abort = 1'b1;
          n.cnt      = 16'h0000;
          if (bp_want) begin
            n.tx.carrier = 1'b1;
            n.col_cnt    = 5'd0;
            n.tx_st      = TX_BPCAR;
          end else if (s.cnt >= slot_c) begin
            n.tx.drop = 1'b1;
            n.col_cnt = 5'd0;
            n.col_ipg = 1'b1;
            n.tx_st   = TX_IPG;
          end else if (col_nx == `SPMFC_MAX_COLL && !s.ctrl[`SPMFC_NOEXC_BIT]) begin
            n.tx.drop = 1'b1;
            n.col_cnt = 5'd0;
            n.col_ipg = 1'b1;
            n.tx_st   = TX_IPG;
          end else begin
            n.col_cnt  = col_nx;
            n.bo_slots = s.lfsr[9:0] & bo_mask;
            n.tx_st    = TX_BOFF;
          end
        end else if (txq.done) begin
          n.col_ipg = (s.col_cnt != 5'd0);
          n.col_cnt = 5'd0;
          n.cnt     = 16'h0000;
          n.tx_st   = TX_IPG;
        end
      end
      TX_BOFF: begin
        if (s.bo_slots == 10'h000) begin
          n.col_ipg = 1'b1;
          n.cnt     = 16'h0000;
          n.tx_st   = TX_IPG;
        end else if (s.cnt >= slot_c - 16'd1) begin
          n.cnt      = 16'h0000;
          n.bo_slots = s.bo_slots - 10'd1;
        end else begin
          n.cnt = s.cnt + 16'd1;
        end
      end
      TX_IPG: begin
        // A retry is sent from IDLE; queue holds the collided frame
        if (s.col_ipg && s.crs_f) begin
          n.cnt = 16'h0000;
        end else if (s.cnt >= ipg_c - 16'd1) begin
          n.col_ipg = 1'b0;
          n.tx_st   = TX_IDLE;
        end else begin
          n.cnt = s.cnt + 16'd1;
        end
      end
      TX_BPCAR: begin
        // Collisions here are ignored: carrier simply stays up
        if (!bp_want || txq.pending) begin
          n.tx.carrier = 1'b0;
          n.col_ipg    = 1'b0;
          n.cnt        = 16'h0000;
          n.tx_st      = TX_IPG;
        end else if (s.cnt >= 16'(`SPMFC_BP_HOLD_CYC) - 16'd1) begin
          n.tx.carrier = 1'b0;
          n.cnt        = 16'h0000;
          n.tx_st      = TX_BPGAP;
        end else begin
          n.cnt = s.cnt + 16'd1;
        end
      end
      TX_BPGAP: begin
        // Silent gap of one inter-packet gap, then carrier returns
        if (!bp_want || txq.pending) begin
          n.cnt   = 16'h0000;
          n.tx_st = TX_IPG;
        end else if (s.cnt >= ipg_c - 16'd1) begin
          n.tx.carrier = 1'b1;
          n.cnt        = 16'h0000;
          n.tx_st      = TX_BPCAR;
        end else begin
          n.cnt = s.cnt + 16'd1;
        end
      end
      default: begin
        n.tx_st = TX_IDLE;
      end
    endcase

    // Bus address phase; read data taken from updated state
    if (hsel && htrans[1] && hready) begin
      n.wr_pend = hwrite;
      n.wr_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          `SPMFC_CTRL_OFS:  n.hrdata = {24'h000000, n.ctrl};
          `SPMFC_MACLO_OFS: n.hrdata = n.mac[31:0];
          `SPMFC_MACHI_OFS: n.hrdata = {16'h0000, n.mac[47:32]};
          `SPMFC_STORM_OFS: n.hrdata = {25'h0000000, n.storm_pct};
          `SPMFC_FCTHR_OFS: n.hrdata = {4'h0, n.thr_off, 4'h0, n.thr_on};
          `SPMFC_STAT_OFS:  n.hrdata = {16'h0000, n.pause_cnt != 16'h0000, n.col_cnt,
                                        n.tx_st, n.tx.carrier, n.fc_req, n.fc_need,
                                        n.crs_f, n.col_f, 2'b00};
          `SPMFC_DROPS_OFS: n.hrdata = {16'h0000, n.drops};
          default:          n.hrdata = 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s             <= '0;
      s.hreadyout   <= 1'b1;
      s.ctrl        <= `SPMFC_CTRL_RST;
      s.storm_pct   <= `SPMFC_STORM_RST;
      s.thr_on      <= `SPMFC_THRON_RST;
      s.thr_off     <= `SPMFC_THROFF_RST;
      s.lfsr        <= `SPMFC_LFSR_RST;
      s.tx_st       <= TX_IDLE;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state flops
  assign hreadyout  = s.hreadyout;
  assign hresp      = s.hresp;
  assign hrdata     = s.hrdata;
  assign tx_out     = s.tx;
  assign pause_sa   = s.mac;
  assign rx_verdict = s.rxv;

endmodule // spmfc_top

// *** rtl/spmfc_cfg.svh ***
// Offsets, field positions, reset values and timing counts for the port MAC
// control block. Assumes a 100 MHz core clock and AHB-Lite register access.
`ifndef SPMFC_CFG_SVH
`define SPMFC_CFG_SVH

// Register byte offsets
`define SPMFC_CTRL_OFS      8'h00
`define SPMFC_MACLO_OFS     8'h04
`define SPMFC_MACHI_OFS     8'h08
`define SPMFC_STORM_OFS     8'h0C
`define SPMFC_FCTHR_OFS     8'h10
`define SPMFC_STAT_OFS      8'h14
`define SPMFC_DROPS_OFS     8'h18

// Control register bit positions
`define SPMFC_JUMBO_BIT     0
`define SPMFC_FCEN_BIT      1
`define SPMFC_BPEN_BIT      2
`define SPMFC_NOEXC_BIT     3
`define SPMFC_STORMEN_BIT   4
`define SPMFC_STORMMC_BIT   5
`define SPMFC_SELFEN_BIT    6

// Reset values
`define SPMFC_CTRL_RST      8'h02
`define SPMFC_STORM_RST     7'h01
`define SPMFC_THRON_RST     12'h040
`define SPMFC_THROFF_RST    12'h080
`define SPMFC_LFSR_RST      16'hACE1

// Frame and protocol figures
`define SPMFC_MIN_LEN       14'd64
`define SPMFC_MAX_STD       14'd1518
`define SPMFC_MAX_JUMBO     14'd9000
`define SPMFC_MAX_COLL      5'd16
`define SPMFC_BO_LIMIT      5'd10
`define SPMFC_PAUSE_MAX     16'hFFFF
`define SPMFC_STORM_UNIT    14'd6250

// Times and derived cycle counts
`define SPMFC_CLK_NS        10
`define SPMFC_IPG_BITS      96
`define SPMFC_SLOT_BITS     512
`define SPMFC_IPG_CYC(b)    ((`SPMFC_IPG_BITS * (b) + `SPMFC_CLK_NS - 1) / `SPMFC_CLK_NS)
`define SPMFC_SLOT_CYC(b)   ((`SPMFC_SLOT_BITS * (b) + `SPMFC_CLK_NS - 1) / `SPMFC_CLK_NS)
`define SPMFC_SLOT_10M_CYC  `SPMFC_SLOT_CYC(100)
`define SPMFC_STORM_1G_MS   5
`define SPMFC_STORM_100M_MS 50
`define SPMFC_STORM_10M_MS  500
`define SPMFC_MS_CYC(m)     ((m) * 1000000 / `SPMFC_CLK_NS)
`define SPMFC_BP_HOLD_US    40
`define SPMFC_BP_HOLD_CYC   (`SPMFC_BP_HOLD_US * 1000 / `SPMFC_CLK_NS)

`endif

// *** rtl/spmfc_pkg.sv ***
// Types for the port MAC control block: link-side carriers, verdicts and
// the single packed state record. Needs nothing from its surroundings.
package spmfc_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_IPG, TX_SEND, TX_BOFF, TX_BPCAR, TX_BPGAP}
    spmfc_tx_st_type;

  typedef enum logic [2:0] {RX_OK, RX_SHORT, RX_LONG, RX_SELF, RX_STORM, RX_PAUSE}
    spmfc_reason_type;

  // Speed code: 0 = 10M, 1 = 100M, 2 = 1000M
  typedef struct packed {
    logic       full_duplex;
    logic [1:0] speed;
  } spmfc_link_type;

  typedef struct packed {
    logic       pending;   // Frames waiting in the egress queue
    logic       done;      // Serializer finished the current frame
  } spmfc_txq_type;

  typedef struct packed {
    logic        start;
    logic        pause_frame;
    logic [15:0] quanta;
    logic        abort;
    logic        drop;
    logic        carrier;
  } spmfc_tx_out_type;

  typedef struct packed {
    logic        eof;
    logic [13:0] len;      // Without VLAN tag, with FCS
    logic [47:0] sa;
    logic        bcast;
    logic        mcast;
    logic        pause;
    logic [15:0] quanta;
  } spmfc_rx_desc_type;

  typedef struct packed {
    logic             valid;
    logic             pass;
    spmfc_reason_type reason;
  } spmfc_rx_verdict_type;

  typedef struct packed {
    logic [11:0] free_buf;
    logic [11:0] free_q;
  } spmfc_res_type;

  typedef struct packed {
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [7:0]           ctrl;
    logic [47:0]          mac;
    logic [6:0]           storm_pct;
    logic [11:0]          thr_on;
    logic [11:0]          thr_off;
    logic [15:0]          drops;
    logic [2:0]           crs_s;
    logic [2:0]           col_s;
    logic                 crs_f;
    logic                 col_f;
    spmfc_tx_st_type      tx_st;
    logic [15:0]          cnt;
    logic [4:0]           col_cnt;
    logic [9:0]           bo_slots;
    logic                 col_ipg;
    logic [15:0]          pause_cnt;
    logic [15:0]          pause_pre;
    logic                 fc_need;
    logic                 fc_req;
    logic [15:0]          fc_quanta;
    logic [15:0]          lfsr;
    logic [25:0]          storm_tmr;
    logic [20:0]          storm_bytes;
    spmfc_tx_out_type     tx;
    spmfc_rx_verdict_type rxv;
  } spmfc_state_type;

endpackage

// *** dv/spmfc_props.sv ***
// Port-level checker for the port MAC control block.
// Assumes binding to spmfc_top; sees its ports only.
`timescale 1ns/10ps
module spmfc_props import spmfc_pkg::*; (
  // Clock, reset, bus answer
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  // Transmit and receive
  input wire spmfc_txq_type        txq,
  input wire spmfc_tx_out_type     tx_out,
  input wire spmfc_rx_desc_type    rx_desc,
  input wire spmfc_rx_verdict_type rx_verdict
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  // Zero-wait slave, always OKAY
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  a_verdict_next: assert property (rx_desc.eof |=> rx_verdict.valid)
    else $error("verdict missing");
  a_verdict_quiet: assert property (!rx_desc.eof |=> !rx_verdict.valid)
    else $error("verdict without frame");
  a_short_drop: assert property (rx_desc.eof && rx_desc.len < 14'd64
    |=> !rx_verdict.pass && rx_verdict.reason == RX_SHORT) else $error("short frame kept");
  a_jumbo_cap: assert property (rx_desc.eof && rx_desc.len > 14'd9000
    |=> rx_verdict.reason == RX_LONG) else $error("oversize frame kept");
  a_start_pulse: assert property (tx_out.start |=> !tx_out.start)
    else $error("start longer than a cycle");
  // Smallest gap is ten cycles at 1000M, so eight quiet cycles hold at every speed
  a_gap_after: assert property (txq.done |=> !tx_out.start [*8])
    else $error("gap too short");
  a_pause_time: assert property (tx_out.start && tx_out.pause_frame
    |-> tx_out.quanta == 16'hFFFF || tx_out.quanta == 16'h0) else $error("odd pause time");
  a_drop_abort: assert property (tx_out.drop |-> tx_out.abort)
    else $error("drop without abort");
  c_short: cover property (rx_desc.eof && rx_desc.len < 14'd64);
  c_pause_tx: cover property (tx_out.start && tx_out.pause_frame);
  c_restart: cover property (txq.done ##[1:40] tx_out.start);
endmodule // spmfc_props

bind spmfc_top spmfc_props u_spmfc_props (.hclk, .hresetn, .hreadyout, .hresp, .txq,
  .tx_out, .rx_desc, .rx_verdict);

// *** dv/spmfc_link_partner.sv ***
// Link partner and serializer model: ends each started frame that is not
// aborted after a programmable time. Collisions come from the bench's jam input.
`timescale 1ns/10ps
module spmfc_link_partner import spmfc_pkg::*; (
  // Clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // Frame length in cycles and transmit side
  input wire logic [7:0]       frame_cyc,
  input wire logic             jam,
  input wire spmfc_tx_out_type tx_out,
  output logic                 done,
  output logic                 crs_pin,
  output logic                 col_pin
);
  logic [7:0] left_q;
  logic       busy_q;
  // One done pulse per start that is not aborted; an aborted frame gives no done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      left_q <= 8'h0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tx_out.start) begin
        busy_q <= 1'b1;
        left_q <= frame_cyc;
      end else if (tx_out.abort) begin
        busy_q <= 1'b0;
      end else if (busy_q && left_q == 8'h0) begin
        busy_q <= 1'b0;
        done   <= 1'b1;
      end else if (busy_q) begin
        left_q <= left_q - 8'h1;
      end
    end
  end
  // Carrier while a frame, back pressure carrier or jam is on the line; jam is the collision
  assign crs_pin = busy_q || tx_out.carrier || jam;
  assign col_pin = jam;
endmodule // spmfc_link_partner

// *** dv/tb_top.sv ***
// Self-checking bench: registers, receive sizes, self filter, received
// pause, frame gap and pause generation. Assumes the partner model.
`timescale 1ns/10ps
module tb_top;
  import spmfc_pkg::*;
  // Stimulus and observed signals
  logic                 hclk = 1'b0;
  logic                 hresetn = 1'b0;
  logic                 hsel = 1'b0;
  logic                 hwrite = 1'b0;
  logic [1:0]           htrans = 2'h0;
  logic [31:0]          haddr = 32'h0;
  logic [31:0]          hwdata = 32'h0;
  logic [31:0]          hrdata, rd;
  logic                 hreadyout, hresp, done, crs_pin, col_pin;
  logic                 pend = 1'b0, jam = 1'b0;
  logic [1:0]           bm = 2'b00;
  logic [7:0]           flen = 8'h14;
  logic [47:0]          pause_sa;
  logic [47:0]          mac = 48'h4567_89AB_CDEF;
  spmfc_link_type       link = 3'h6;
  spmfc_res_type        res = 24'hFFFFFF;
  spmfc_rx_desc_type    rx_desc = '0;
  spmfc_tx_out_type     tx_out;
  spmfc_rx_verdict_type rx_verdict;
  int                   fail_count = 0, total_checks = 0, seed = 27788, n, l;
  int                   lens[6] = '{63, 64, 1518, 1519, 9000, 9001};
  wire spmfc_txq_type   txq = {pend, done};
  wire logic [2:0]      ev = {tx_out.abort, done, tx_out.start};
  ////////////////////////////////////////////////////////////
  spmfc_top #(.P_SLOT_10M_CYC(64), .P_STORM_1G_CYC(200), .P_STORM_100M_CYC(400),
    .P_STORM_10M_CYC(800)) u_spmfc_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .link, .crs_pin, .col_pin, .txq, .res, .tx_out, .pause_sa, .rx_desc, .rx_verdict);
  spmfc_link_partner u_spmfc_link_partner (.hclk, .hresetn, .frame_cyc(flen), .tx_out,
    .jam, .done, .crs_pin, .col_pin);
  always #5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Edge by edge until hready, bounded so a dead slave ends the run
  task automatic hwait;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
      if (k > 50) begin
        check(1'b0, "bus hang");
        end_of_test();
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    hwait();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask
  task automatic rx(input logic [13:0] len, input logic [47:0] sa, input logic ps,
                    input logic [15:0] q);
    @(posedge hclk);
    rx_desc <= '{1'b1, len, sa, bm[1], bm[0], ps, q};
    @(posedge hclk);
    rx_desc.eof <= 1'b0;
    #1;
    check(rx_verdict.valid === 1'b1, "verdict missing");
  endtask
  task automatic idle_for(input int c, input string m);
    int bad;
    bad = 0;
    repeat (c) begin
      @(posedge hclk);
      #1;
      if (tx_out.start !== 1'b0) bad++;
    end
    check(bad == 0, m);
  endtask
  // Waits for a start (0), frame end (1) or abort (2), counting cycles in n
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
      if (n > lim) begin
        check(1'b0, "event never came");
        end_of_test();
      end
    end while (ev[sel] !== 1'b1);
  endtask
  function automatic spmfc_reason_type size_verdict(input int len, input logic jumbo);
    if (len < 64) return RX_SHORT;
    if (len > (jumbo ? 9000 : 1518)) return RX_LONG;
    return RX_OK;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, a hole in the map, switch address
    ahb(1'b0, 8'h00, 32'h0);
    check(rd === 32'h2, "control reset");
    ahb(1'b0, 8'h0C, 32'h0);
    check(rd === 32'h1, "storm rate reset");
    ahb(1'b0, 8'h10, 32'h0);
    check(rd === 32'h0080_0040, "threshold reset");
    ahb(1'b0, 8'h1C, 32'h0);
    check(rd === 32'h0, "unmapped read");
    ahb(1'b1, 8'h04, mac[31:0]);
    ahb(1'b1, 8'h08, {16'h0, mac[47:32]});
    ahb(1'b0, 8'h08, 32'h0);
    check(rd === {16'h0, mac[47:32]}, "address high");
    // Size limits, corners first, standard then jumbo maximum
    for (int j = 0; j < 2; j++) begin
      ahb(1'b1, 8'h00, 32'h2 | 32'(j));
      for (int i = 0; i < 12; i++) begin
        l = (i < 6) ? lens[i] : $unsigned($random(seed)) % 9100;
        rx(l[13:0], 48'h1, 1'b0, 16'h0);
        check(rx_verdict.reason === size_verdict(l, j[0]), "size reason");
        check(rx_verdict.pass === (size_verdict(l, j[0]) == RX_OK), "size pass");
      end
    end
    // Own source address dropped once filtering is on
    ahb(1'b1, 8'h00, 32'h42);
    rx(14'h64, mac, 1'b0, 16'h0);
    check(rx_verdict.reason === RX_SELF && rx_verdict.pass === 1'b0, "self drop");
    ahb(1'b1, 8'h00, 32'h2);
    // Received pause, reloaded part way, holds the queued frame
    rx(14'h40, 48'h2, 1'b1, 16'h2);
    check(rx_verdict.reason === RX_PAUSE, "pause consumed");
    pend <= 1'b1;
    idle_for(40, "start while paused");
    rx(14'h40, 48'h2, 1'b1, 16'h3);
    idle_for(100, "start after reload");
    wait_for(0, 300);
    check(tx_out.pause_frame === 1'b0, "normal frame");
    // Gap after a clean frame, queue still full
    wait_for(1, 300);
    wait_for(0, 300);
    pend <= 1'b0;
    check(n >= 10, "gap after frame");
    // Pause generation with hysteresis, slow partner
    flen <= 8'h40;
    res.free_q <= 12'h80 + 12'($unsigned($random(seed)) % 3968);
    res.free_buf <= 12'h020;
    wait_for(0, 100);
    check(tx_out.pause_frame === 1'b1 && tx_out.quanta === 16'hFFFF, "pause on");
    check(pause_sa === mac, "pause source");
    res.free_buf <= 12'h060;
    idle_for(200, "pause toggled");
    res.free_buf <= 12'h100;
    wait_for(0, 100);
    check(tx_out.pause_frame === 1'b1 && tx_out.quanta === 16'h0, "pause off");
    // Storm limit of 6250 bytes; one interval edge may split the burst
    bm <= 2'b10;
    ahb(1'b1, 8'h00, 32'h13);
    l = 0;
    for (int i = 0; i < 3; i++) begin
      rx(14'd4000, 48'h3, 1'b0, 16'h0);
      l += (rx_verdict.reason === RX_STORM);
    end
    check(l == 1 || l == 2, "storm not limited");
    bm <= 2'b01;
    rx(14'd4000, 48'h3, 1'b0, 16'h0);
    check(rx_verdict.pass === 1'b1, "multicast counted");
    bm <= 2'b10;
    repeat (210) @(posedge hclk);
    rx(14'd4000, 48'h3, 1'b0, 16'h0);
    check(rx_verdict.pass === 1'b1, "interval not cleared");
    // Half duplex: back pressure carrier, its gap, queued frame, collisions
    bm <= 2'b00;
    flen <= 8'h80;
    link.full_duplex <= 1'b0;
    ahb(1'b1, 8'h00, 32'h0E);
    res.free_buf <= 12'h020;
    idle_for(8, "start in back pressure");
    check(tx_out.carrier === 1'b1, "no carrier");
    l = 0;
    repeat (4100) begin
      @(posedge hclk);
      #1;
      l += (tx_out.carrier === 1'b0);
    end
    check(l > 0 && l < 20 && tx_out.carrier === 1'b1, "carrier gap");
    pend <= 1'b1;
    wait_for(0, 40);
    check(tx_out.carrier === 1'b0, "carrier kept for frame");
    repeat (5) @(posedge hclk);
    jam <= 1'b1;
    wait_for(2, 20);
    jam <= 1'b0;
    res.free_buf <= 12'h100;
    check(tx_out.carrier === 1'b1 && tx_out.drop === 1'b0, "no carrier after jam");
    wait_for(0, 40);
    repeat (5) @(posedge hclk);
    jam <= 1'b1;
    wait_for(2, 20);
    check(tx_out.drop === 1'b0, "early collision dropped");
    repeat (20) @(posedge hclk);
    jam <= 1'b0;
    wait_for(0, 300);
    check(n >= 10, "gap before carrier fell");
    repeat (60) @(posedge hclk);
    jam <= 1'b1;
    wait_for(2, 20);
    jam <= 1'b0;
    pend <= 1'b0;
    check(tx_out.drop === 1'b1, "late collision retried");
    end_of_test();
  end
endmodule // tb_top
